// ===== rtl/ddl_loader.sv
`timescale 1ns/100ps
// Overview of operation
// - clear empties shifter, zeroes both latches
// - cleared output zero, offset binary negative
// - each channel has own range setting
// - format select high means twos complement
// - offset binary is twos complement, MSB inverted
// - three ignored, channel bit, twelve data bits
// - natural binary, one step per code
// - sixteen bits sampled on falling clock edges
// - automatic or strobe-driven latch update
// - only sixteen edges after frame accepted
// - strobe low at frame: update on sixteenth
// - strobe high: both latches on its fall
module ddl_loader (
	input wire logic sys_clk, // system clock, 100 MHz
	input wire logic resetn, // async reset, active low
	input wire logic serial_clk, // link serial clock
	input wire logic frame_sync_n, // frame sync, active low
	input wire logic serial_data_in, // serial data, msb first
	input wire logic latch_load_n, // load strobe, active low
	input wire logic clear_strobe_n, // async clear, active low
	input wire logic code_format_sel, // 1 twos complement, 0 binary
	input wire logic [ddl_pkg::DDL_RANGE_W-1:0] range_offset_input_a, // range of channel a
	input wire logic [ddl_pkg::DDL_RANGE_W-1:0] range_offset_input_b, // range of channel b
	input wire logic psel, // apb select
	input wire logic penable, // apb enable
	input wire logic pwrite, // apb direction
	input wire logic [ddl_pkg::DDL_ADDR_W-1:0] paddr, // apb byte address
	input wire logic [31:0] pwdata, // apb write data
	output logic [31:0] prdata, // apb read data
	output logic pready, // apb ready
	output logic pslverr, // apb error
	output logic [ddl_pkg::DDL_DATA_BITS-1:0] dac_code_a, // converter code a
	output logic [ddl_pkg::DDL_DATA_BITS-1:0] dac_code_b, // converter code b
	output logic [ddl_pkg::DDL_RANGE_W-1:0] range_cfg_a, // range setting a
	output logic [ddl_pkg::DDL_RANGE_W-1:0] range_cfg_b // range setting b
);
	import ddl_pkg::*;

	// ==========================================================
	// link domain: shift register on falling serial clock
	logic link_rst_n;
	logic cnt_rst_n;
	logic [DDL_CNT_W-1:0] bit_cnt;
	logic [DDL_CNT_W-1:0] next_bit_cnt;
	logic [DDL_WORD_BITS-1:0] shift;
	logic [DDL_WORD_BITS-1:0] next_shift;
	logic [DDL_WORD_BITS-1:0] word_hold;
	logic [DDL_WORD_BITS-1:0] next_word_hold;
	logic word_tgl;
	logic next_word_tgl;

	assign link_rst_n = resetn & clear_strobe_n;
	// counter held at zero while no frame is open
	assign cnt_rst_n = link_rst_n & ~frame_sync_n;

	always_comb begin
		next_bit_cnt = bit_cnt;
		next_shift = shift;
		if (bit_cnt != DDL_CNT_DONE) begin
			next_shift = {shift[DDL_WORD_BITS-2:0], serial_data_in};
			next_bit_cnt = bit_cnt + DDL_CNT_STEP;
		end
	end

	always_ff @(negedge serial_clk or negedge cnt_rst_n) begin
		if (!cnt_rst_n) begin
			bit_cnt <= DDL_CNT_RST;
			shift <= DDL_WORD_RST;
		end else begin
			bit_cnt <= next_bit_cnt;
			shift <= next_shift;
		end
	end

	always_comb begin
		next_word_hold = word_hold;
		next_word_tgl = word_tgl;
		if (bit_cnt == DDL_CNT_LAST) begin
			next_word_hold = {shift[DDL_WORD_BITS-2:0], serial_data_in};
			next_word_tgl = ~word_tgl;
		end
	end

	always_ff @(negedge serial_clk or negedge link_rst_n) begin
		if (!link_rst_n) begin
			word_hold <= DDL_WORD_RST;
			word_tgl <= 1'b0;
		end else begin
			word_hold <= next_word_hold;
			word_tgl <= next_word_tgl;
		end
	end

	// ==========================================================
	// crossings into the system domain
	logic tgl_s;
	logic frame_s;
	logic load_s;
	logic fmt_s;
	logic [DDL_RANGE_W-1:0] range_a_s;
	logic [DDL_RANGE_W-1:0] range_b_s;

	// word_hold skips the synchroniser: it is stable whenever the toggle arrives
	ddl_sync2 #(
		.WIDTH(4 + 2 * DDL_RANGE_W)
	) u_sync (
		.clk(sys_clk),
		.rst_n(resetn),
		.d({word_tgl, frame_sync_n, latch_load_n, code_format_sel,
			range_offset_input_a, range_offset_input_b}),
		.q({tgl_s, frame_s, load_s, fmt_s, range_a_s, range_b_s})
	);

	assign range_cfg_a = range_a_s;
	assign range_cfg_b = range_b_s;

	// ==========================================================
	// edge detection after the synchronisers
	logic tgl_d;
	logic frame_d;
	logic load_d;
	logic next_tgl_d;
	logic next_frame_d;
	logic next_load_d;
	logic word_new;
	logic frame_fall;
	logic load_fall;

	always_comb begin
		next_tgl_d = tgl_s;
		next_frame_d = frame_s;
		next_load_d = load_s;
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			tgl_d <= 1'b0;
			frame_d <= 1'b0;
			load_d <= 1'b0;
		end else begin
			tgl_d <= next_tgl_d;
			frame_d <= next_frame_d;
			load_d <= next_load_d;
		end
	end

	assign word_new = tgl_s ^ tgl_d;
	assign frame_fall = frame_d & ~frame_s;
	assign load_fall = load_d & ~load_s;

	// ==========================================================
	// channel latches and update modes
	logic sys_rst_n;
	logic clr_rst_n;
	logic soft_load;
	ddl_mode_t mode;
	ddl_mode_t next_mode;
	logic [DDL_DATA_BITS-1:0] latch_a;
	logic [DDL_DATA_BITS-1:0] latch_b;
	logic [DDL_DATA_BITS-1:0] pend_a;
	logic [DDL_DATA_BITS-1:0] pend_b;
	logic [DDL_DATA_BITS-1:0] next_latch_a;
	logic [DDL_DATA_BITS-1:0] next_latch_b;
	logic [DDL_DATA_BITS-1:0] next_pend_a;
	logic [DDL_DATA_BITS-1:0] next_pend_b;
	logic [DDL_DATA_BITS-1:0] next_dac_code_a;
	logic [DDL_DATA_BITS-1:0] next_dac_code_b;
	logic [DDL_DATA_BITS-1:0] fmt_mask;
	logic [DDL_DATA_BITS-1:0] word_data;
	logic word_sel;
	logic [7:0] word_cnt;
	logic [7:0] next_word_cnt;

	// clear acts at once, but releases in step with sys_clk
	assign clr_rst_n = resetn & clear_strobe_n;

	ddl_sync2 #(
		.WIDTH(1)
	) u_clr_sync (
		.clk(sys_clk),
		.rst_n(clr_rst_n),
		.d(1'b1),
		.q(sys_rst_n)
	);

	assign word_data = word_hold[DDL_DATA_BITS-1:0];
	assign word_sel = word_hold[DDL_SEL_POS];

	always_comb begin
		next_mode = mode;
		next_latch_a = latch_a;
		next_latch_b = latch_b;
		next_pend_a = pend_a;
		next_pend_b = pend_b;
		next_word_cnt = word_cnt;
		if (frame_fall) begin
			next_mode = load_s ? DDL_MD_HOLD : DDL_MD_AUTO;
		end
		if (word_new) begin
			next_word_cnt = word_cnt + DDL_WCNT_STEP;
			unique case (mode)
				DDL_MD_AUTO: begin
					if (word_sel) begin
						next_latch_b = word_data;
					end else begin
						next_latch_a = word_data;
					end
				end
				DDL_MD_IDLE, DDL_MD_HOLD: begin
					if (word_sel) begin
						next_pend_b = word_data;
					end else begin
						next_pend_a = word_data;
					end
				end
			endcase
		end
		if ((load_fall || soft_load) && mode != DDL_MD_AUTO) begin
			next_latch_a = next_pend_a;
			next_latch_b = next_pend_b;
		end
		// straight binary to the converter; twos complement flips msb
		fmt_mask = fmt_s ? DDL_MSB_MASK : DDL_LATCH_RST;
		next_dac_code_a = next_latch_a ^ fmt_mask;
		next_dac_code_b = next_latch_b ^ fmt_mask;
	end

	always_ff @(posedge sys_clk or negedge sys_rst_n) begin
		if (!sys_rst_n) begin
			mode <= DDL_MD_IDLE;
			latch_a <= DDL_LATCH_RST;
			latch_b <= DDL_LATCH_RST;
			pend_a <= DDL_LATCH_RST;
			pend_b <= DDL_LATCH_RST;
			word_cnt <= DDL_WCNT_RST;
			dac_code_a <= DDL_LATCH_RST;
			dac_code_b <= DDL_LATCH_RST;
		end else begin
			mode <= next_mode;
			latch_a <= next_latch_a;
			latch_b <= next_latch_b;
			pend_a <= next_pend_a;
			pend_b <= next_pend_b;
			word_cnt <= next_word_cnt;
			dac_code_a <= next_dac_code_a;
			dac_code_b <= next_dac_code_b;
		end
	end

	// ==========================================================
	// apb slave: one wait state, then registered answer
	logic next_pready;
	logic next_pslverr;
	logic next_soft_load;
	logic [31:0] next_prdata;
	logic [31:0] status_word;
	logic access;

	assign access = psel & penable;

	always_comb begin
		status_word = 32'h0000_0000;
		status_word[DDL_STAT_AUTO_BIT] = (mode == DDL_MD_AUTO);
		status_word[DDL_STAT_HOLD_BIT] = (mode == DDL_MD_HOLD);
		status_word[DDL_STAT_FMT_BIT] = fmt_s;
		status_word[DDL_STAT_CNT_LSB +: 8] = word_cnt;
		next_pready = access & ~pready;
		next_prdata = prdata;
		next_pslverr = 1'b0;
		next_soft_load = access & pready & pwrite & (paddr == DDL_OFS_CTRL)
			& pwdata[DDL_CTRL_LOAD_BIT];
		if (access && !pready) begin
			unique case (paddr)
				DDL_OFS_CODE_A: next_prdata = {20'h0_0000, latch_a};
				DDL_OFS_CODE_B: next_prdata = {20'h0_0000, latch_b};
				DDL_OFS_STATUS: next_prdata = status_word;
				DDL_OFS_CTRL: next_prdata = DDL_RDATA_RST;
				default: begin
					next_prdata = DDL_RDATA_RST;
					next_pslverr = 1'b1;
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			pready <= 1'b0;
			prdata <= DDL_RDATA_RST;
			pslverr <= 1'b0;
			soft_load <= 1'b0;
		end else begin
			pready <= next_pready;
			prdata <= next_prdata;
			pslverr <= next_pslverr;
			soft_load <= next_soft_load;
		end
	end
endmodule

// ===== rtl/ddl_pkg.sv
package ddl_pkg;

	// ==========================================================
	// serial word layout
	localparam int DDL_WORD_BITS = 16;
	localparam int DDL_DATA_BITS = 12;
	localparam int DDL_SEL_POS = 12;
	localparam int DDL_CNT_W = 5;
	localparam int DDL_RANGE_W = 2;
	localparam logic [4:0] DDL_CNT_RST = 5'h00;
	localparam logic [4:0] DDL_CNT_LAST = 5'h0F;
	localparam logic [4:0] DDL_CNT_DONE = 5'h10;
	localparam logic [4:0] DDL_CNT_STEP = 5'h01;

	// ==========================================================
	// reset values and code conversion
	localparam logic [15:0] DDL_WORD_RST = 16'h0000;
	localparam logic [11:0] DDL_LATCH_RST = 12'h000;
	localparam logic [11:0] DDL_MSB_MASK = 12'h800;
	localparam logic [7:0] DDL_WCNT_RST = 8'h00;
	localparam logic [7:0] DDL_WCNT_STEP = 8'h01;
	localparam logic [31:0] DDL_RDATA_RST = 32'h0000_0000;

	// ==========================================================
	// register map (byte addresses)
	localparam int DDL_ADDR_W = 8;
	localparam logic [7:0] DDL_OFS_CODE_A = 8'h00;
	localparam logic [7:0] DDL_OFS_CODE_B = 8'h04;
	localparam logic [7:0] DDL_OFS_STATUS = 8'h08;
	localparam logic [7:0] DDL_OFS_CTRL = 8'h0C;
	localparam int DDL_CTRL_LOAD_BIT = 0;
	localparam int DDL_STAT_AUTO_BIT = 0;
	localparam int DDL_STAT_HOLD_BIT = 1;
	localparam int DDL_STAT_FMT_BIT = 2;
	localparam int DDL_STAT_CNT_LSB = 8;

	// ==========================================================
	// update mode of the current frame
	typedef enum logic [2:0] {
		DDL_MD_IDLE = 3'b001,
		DDL_MD_AUTO = 3'b010,
		DDL_MD_HOLD = 3'b100
	} ddl_mode_t;

endpackage

// ===== rtl/ddl_sync2.sv
`timescale 1ns/100ps
module ddl_sync2 #(
	parameter int WIDTH = 1
) (
	input wire logic clk, // destination clock
	input wire logic rst_n, // async reset, active low
	input wire logic [WIDTH-1:0] d, // asynchronous inputs
	output logic [WIDTH-1:0] q // synchronised outputs
);
	logic [WIDTH-1:0] stage1;
	logic [WIDTH-1:0] next_stage1;
	logic [WIDTH-1:0] next_q;

	always_comb begin
		next_stage1 = d;
		next_q = stage1;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			stage1 <= '0;
			q <= '0;
		end else begin
			stage1 <= next_stage1;
			q <= next_q;
		end
	end
endmodule

// ===== verification/ddl_asserts.sv
`timescale 1ns/100ps
module ddl_asserts
	import ddl_pkg::*;
(
	input wire logic sys_clk, // clock
	input wire logic resetn, // reset
	input wire logic frame_sync_n, // frame
	input wire logic latch_load_n, // strobe
	input wire logic clear_strobe_n, // clear
	input wire logic code_format_sel, // format
	input wire logic [1:0] range_offset_input_a, // range in
	input wire logic [1:0] range_offset_input_b, // range in
	input wire logic psel, // apb
	input wire logic pwrite, // apb
	input wire logic [7:0] paddr, // apb
	input wire logic [31:0] prdata, // apb
	input wire logic pready, // apb
	input wire logic [11:0] dac_code_a, // code
	input wire logic [11:0] dac_code_b, // code
	input wire logic [1:0] range_cfg_a, // range out
	input wire logic [1:0] range_cfg_b // range out
);
	// ==========================================================
	// helpers
	logic [2:0] age;
	logic fmt_d;
	logic settled;
	logic quiet;
	logic [11:0] mask;
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			age <= 3'h0;
			fmt_d <= 1'b0;
		end else begin
			age <= (age == 3'h7) ? age : age + 3'h1;
			fmt_d <= code_format_sel;
		end
	end
	assign settled = (age == 3'h7) && (code_format_sel == fmt_d);
	assign quiet = settled && clear_strobe_n && latch_load_n && !psel;
	assign mask = code_format_sel ? DDL_MSB_MASK : 12'h000;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!resetn);
	sequence s_code_rd(a);
		(settled && frame_sync_n)[*6] ##0 (pready && !pwrite && paddr == a);
	endsequence
	sequence s_cleared;
		(!clear_strobe_n && code_format_sel)[*3] ##1
			(clear_strobe_n && code_format_sel && frame_sync_n)[*4];
	endsequence
	// ==========================================================
	// properties
	a_clear_bin: assert property ((!clear_strobe_n && !code_format_sel && settled)[*5]
		|-> dac_code_a == 12'h000 && dac_code_b == 12'h000) else $error("clear code not zero");
	a_clear_twos: assert property (s_cleared
		|-> dac_code_a == 12'h800 && dac_code_b == 12'h800) else $error("clear code not mid");
	a_range_a: assert property (($stable(range_offset_input_a) && age == 3'h7)[*4]
		|-> range_cfg_a == range_offset_input_a) else $error("range a wrong");
	a_range_b: assert property (($stable(range_offset_input_b) && age == 3'h7)[*4]
		|-> range_cfg_b == range_offset_input_b) else $error("range b wrong");
	a_fmt_map_a: assert property (s_code_rd(DDL_OFS_CODE_A)
		|-> dac_code_a == (prdata[11:0] ^ mask)) else $error("code a format wrong");
	a_fmt_map_b: assert property (s_code_rd(DDL_OFS_CODE_B)
		|-> dac_code_b == (prdata[11:0] ^ mask)) else $error("code b format wrong");
	a_hold_still: assert property (quiet[*8]
		|-> $stable(dac_code_a) && $stable(dac_code_b)) else $error("code moved unloaded");
	a_clear_wins: assert property ((!clear_strobe_n && settled)[*6]
		|-> $stable(dac_code_a) && $stable(dac_code_b)) else $error("code moved in clear");
endmodule
bind ddl_loader ddl_asserts u_chk (
	.sys_clk(sys_clk),
	.resetn(resetn),
	.frame_sync_n(frame_sync_n),
	.latch_load_n(latch_load_n),
	.clear_strobe_n(clear_strobe_n),
	.code_format_sel(code_format_sel),
	.range_offset_input_a(range_offset_input_a),
	.range_offset_input_b(range_offset_input_b),
	.psel(psel),
	.pwrite(pwrite),
	.paddr(paddr),
	.prdata(prdata),
	.pready(pready),
	.dac_code_a(dac_code_a),
	.dac_code_b(dac_code_b),
	.range_cfg_a(range_cfg_a),
	.range_cfg_b(range_cfg_b)
);

// ===== verification/ddl_host.sv
`timescale 1ns/100ps
// ==========================================================
// host serial port, clock idles low
module ddl_host (
	output logic serial_clk, // link clock
	output logic frame_sync_n, // frame, active low
	output logic serial_data_in // data
);
	initial begin
		serial_clk = 1'b0;
		frame_sync_n = 1'b1;
		serial_data_in = 1'b0;
	end
	// data launched on rise, sampled by the device on the fall
	task automatic send_word(input logic [15:0] w, input int edges);
		#7 frame_sync_n = 1'b0;
		for (int i = 0; i < edges; i++) begin
			serial_clk = 1'b1;
			serial_data_in = (i < 16) ? w[15 - i] : ~serial_data_in;
			#32 serial_clk = 1'b0;
			#32;
		end
		frame_sync_n = 1'b1;
		serial_data_in = ~serial_data_in;
	endtask
endmodule

// ===== verification/tb_top.sv
`timescale 1ns/100ps
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin miscompares++; \
	$display("MISMATCH %s exp %h got %h", nm, e, g); end end
module tb_top;
	import ddl_pkg::*;
	logic sys_clk, resetn, latch_load_n, clear_strobe_n, code_format_sel, err;
	logic serial_clk, frame_sync_n, serial_data_in;
	logic [1:0] range_offset_input_a, range_offset_input_b, range_cfg_a, range_cfg_b;
	logic psel, penable, pwrite, pready, pslverr;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [11:0] dac_code_a, dac_code_b;
	int miscompares = 0;
	int checks_done = 0;
	int cycles = 0;
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	ddl_host host (
		.serial_clk(serial_clk),
		.frame_sync_n(frame_sync_n),
		.serial_data_in(serial_data_in)
	);
	ddl_loader DUT (
		.sys_clk(sys_clk),
		.resetn(resetn),
		.serial_clk(serial_clk),
		.frame_sync_n(frame_sync_n),
		.serial_data_in(serial_data_in),
		.latch_load_n(latch_load_n),
		.clear_strobe_n(clear_strobe_n),
		.code_format_sel(code_format_sel),
		.range_offset_input_a(range_offset_input_a),
		.range_offset_input_b(range_offset_input_b),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr),
		.dac_code_a(dac_code_a),
		.dac_code_b(dac_code_b),
		.range_cfg_a(range_cfg_a),
		.range_cfg_b(range_cfg_b)
	);
	// ==========================================================
	// tasks
	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
	endtask
	task automatic end_sim();
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		do begin
			@(posedge sys_clk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0000_0000);
		`CHK("prdata", e, rd)
	endtask
	task automatic codes(input logic [11:0] ea, input logic [11:0] eb);
		tick(8);
		`CHK("code_a", ea, dac_code_a)
		`CHK("code_b", eb, dac_code_b)
	endtask
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 5000) begin
			miscompares++;
			end_sim();
		end
	end
	// ==========================================================
	// main sequence
	initial begin
		{resetn, psel, penable, pwrite, code_format_sel} = 5'h00;
		{latch_load_n, clear_strobe_n} = 2'h3;
		{range_offset_input_a, range_offset_input_b} = 4'h6;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		tick(5);
		resetn <= 1'b1;
		rd_chk(DDL_OFS_CODE_A, 32'h0000_0000);
		apb(1'b0, 8'h10, 32'h0000_0000);
		`CHK("pslverr", 1'b1, err)
		@(posedge sys_clk) range_offset_input_a <= 2'h3;
		tick(4);
		`CHK("range_a", 2'h3, range_cfg_a)
		`CHK("range_b", 2'h2, range_cfg_b)
		$display("test reset done");
		host.send_word(16'hEABC, 16);
		tick(4);
		host.send_word(16'h7123, 20);
		codes(12'h000, 12'h000);
		@(posedge sys_clk) latch_load_n <= 1'b0;
		codes(12'hABC, 12'h123);
		@(posedge sys_clk) latch_load_n <= 1'b1;
		$display("test hold done");
		tick(4);
		@(posedge sys_clk) latch_load_n <= 1'b0;
		tick(4);
		host.send_word(16'h05A5, 16);
		codes(12'h5A5, 12'h123);
		host.send_word(16'h1F00, 8);
		codes(12'h5A5, 12'h123);
		@(posedge sys_clk) latch_load_n <= 1'b1;
		$display("test auto done");
		@(posedge sys_clk) code_format_sel <= 1'b1;
		codes(12'hDA5, 12'h923);
		rd_chk(DDL_OFS_CODE_B, 32'h0000_0123);
		host.send_word(16'h0321, 16);
		tick(4);
		host.send_word(16'h1456, 16);
		tick(6);
		apb(1'b1, DDL_OFS_CTRL, 32'h0000_0001);
		codes(12'hB21, 12'hC56);
		rd_chk(DDL_OFS_STATUS, 32'h0000_0506);
		$display("test format done");
		@(posedge sys_clk) clear_strobe_n <= 1'b0;
		tick(4);
		@(posedge sys_clk) clear_strobe_n <= 1'b1;
		codes(12'h800, 12'h800);
		rd_chk(DDL_OFS_CODE_A, 32'h0000_0000);
		@(posedge sys_clk) begin
			code_format_sel <= 1'b0;
			latch_load_n <= 1'b0;
		end
		tick(6);
		fork
			host.send_word(16'h0FFF, 16);
			begin
				tick(30);
				clear_strobe_n <= 1'b0;
				tick(20);
				clear_strobe_n <= 1'b1;
			end
		join
		codes(12'h000, 12'h000);
		$display("test clear done");
		end_sim();
	end
endmodule
